/* rtl/sbsz_consts.vh */
`ifndef SBSZ_CONSTS_VH
`define SBSZ_CONSTS_VH

// ************************************************************
// operation codes on i_op_code
// ************************************************************
`define SBSZ_OP_NONE 2'h0
`define SBSZ_OP_SUB_TO_ACCUM 2'h1
`define SBSZ_OP_SUB_MEM 2'h2
`define SBSZ_OP_DEC_SKIP 2'h3

// ************************************************************
// register offsets on the software port
// ************************************************************
`define SBSZ_REG_ACCUM 3'h0
`define SBSZ_REG_FLAGS 3'h1
`define SBSZ_REG_RESULT 3'h2
`define SBSZ_REG_SKIPS 3'h3
`define SBSZ_REG_STATE 3'h4

// ************************************************************
// flag register bit positions
// ************************************************************
`define SBSZ_FLAG_C 0
`define SBSZ_FLAG_AUX_CARRY 1
`define SBSZ_FLAG_Z 2
`define SBSZ_FLAG_OVERFLOW 3

// ************************************************************
// reset values
// ************************************************************
`define SBSZ_RST_ACCUM 8'h00
`define SBSZ_RST_FLAGS 4'h0
`define SBSZ_RST_BYTE 8'h00

// ************************************************************
// timing counts, in core cycles
// ************************************************************
`define SBSZ_DUMMY_CYCLES 2'h1

`endif

/* rtl/sbsz_core.v */
`timescale 1ns/100ps
`include "sbsz_consts.vh"

module sbsz_core #(
  parameter DATA_W = 8,
  parameter ADDR_W = 3
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_op_valid,
  input wire [1:0] i_op_code,
  input wire [DATA_W-1:0] i_mem_data,
  output wire o_op_ready,
  output wire o_mem_wr_en,
  output wire [DATA_W-1:0] o_mem_wr_data,
  output wire o_skip_req,
  output wire o_dummy_cycle,
  output wire [DATA_W-1:0] o_accumulator,
  output wire o_carry_flag,
  output wire o_aux_carry_flag,
  output wire o_zero_flag,
  output wire o_overflow_flag,
  input wire [ADDR_W-1:0] i_reg_addr,
  input wire [DATA_W-1:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output wire [DATA_W-1:0] o_reg_rdata
);

  // ************************************************************
  // states of the skip sequencer
  // ************************************************************
  localparam ST_RUN = 1'b0;
  localparam ST_DUMMY = 1'b1;

  // ************************************************************
  // decode helpers
  // ************************************************************
  function is_sub_op;
    input [1:0] code;
    begin
      is_sub_op = (code == `SBSZ_OP_SUB_TO_ACCUM) || (code == `SBSZ_OP_SUB_MEM);
    end
  endfunction

  function reg_hit;
    input [ADDR_W-1:0] addr;
    input [2:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  reg state_q;
  reg state_d;
  reg [1:0] dummy_cnt_q;
  reg [1:0] dummy_cnt_d;
  reg [DATA_W-1:0] acc_q;
  reg [DATA_W-1:0] acc_d;
  reg c_q;
  reg c_d;
  reg ac_q;
  reg ac_d;
  reg z_q;
  reg z_d;
  reg ov_q;
  reg ov_d;
  reg mem_wr_q;
  reg mem_wr_d;
  reg [DATA_W-1:0] mem_data_q;
  reg [DATA_W-1:0] mem_data_d;
  reg skip_q;
  reg skip_d;
  reg [DATA_W-1:0] result_q;
  reg [DATA_W-1:0] result_d;
  reg [DATA_W-1:0] skips_q;
  reg [DATA_W-1:0] skips_d;
  reg [DATA_W-1:0] rdata_q;
  reg [DATA_W-1:0] rdata_d;

  // ************************************************************
  // subtract with borrow datapath
  // ************************************************************
  wire borrow_in;
  wire [DATA_W:0] diff_full;
  wire [4:0] diff_low;
  wire [DATA_W-1:0] diff;
  wire sub_c;
  wire sub_ac;
  wire sub_z;
  wire sub_ov;

  // borrow in is the complement of the carry flag
  assign borrow_in = ~c_q;
  assign diff_full = {1'b0, acc_q} - {1'b0, i_mem_data} - {{DATA_W{1'b0}}, borrow_in};
  assign diff_low = {1'b0, acc_q[3:0]} - {1'b0, i_mem_data[3:0]} - {4'h0, borrow_in};
  assign diff = diff_full[DATA_W-1:0];
  // carry set means no borrow out: result zero or positive
  assign sub_c = ~diff_full[DATA_W];
  assign sub_ac = ~diff_low[4];
  assign sub_z = (diff == {DATA_W{1'b0}});
  assign sub_ov = (acc_q[DATA_W-1] ^ i_mem_data[DATA_W-1]) &
                  (diff[DATA_W-1] ^ acc_q[DATA_W-1]);

  // ************************************************************
  // decrement datapath
  // ************************************************************
  wire [DATA_W-1:0] dec_val;
  wire dec_zero;

  // decrement first, then test the decremented value
  assign dec_val = i_mem_data - {{(DATA_W-1){1'b0}}, 1'b1};
  assign dec_zero = (dec_val == {DATA_W{1'b0}});

  // ************************************************************
  // operation acceptance
  // ************************************************************
  wire op_go;

  // no new operation while the dummy fetch cycle is running
  assign o_op_ready = (state_q == ST_RUN);
  assign op_go = i_op_valid & o_op_ready;

  // ************************************************************
  // accumulator and flags, with software writes below operations
  // ************************************************************
  always @* begin
    acc_d = acc_q;
    c_d = c_q;
    ac_d = ac_q;
    z_d = z_q;
    ov_d = ov_q;
    if (i_reg_wr && reg_hit(i_reg_addr, `SBSZ_REG_ACCUM)) begin
      acc_d = i_reg_wdata;
    end
    if (i_reg_wr && reg_hit(i_reg_addr, `SBSZ_REG_FLAGS)) begin
      c_d = i_reg_wdata[`SBSZ_FLAG_C];
      ac_d = i_reg_wdata[`SBSZ_FLAG_AUX_CARRY];
      z_d = i_reg_wdata[`SBSZ_FLAG_Z];
      ov_d = i_reg_wdata[`SBSZ_FLAG_OVERFLOW];
    end
    if (op_go && is_sub_op(i_op_code)) begin
      c_d = sub_c;
      ac_d = sub_ac;
      z_d = sub_z;
      ov_d = sub_ov;
    end
    if (op_go && (i_op_code == `SBSZ_OP_SUB_TO_ACCUM)) begin
      acc_d = diff;
    end
  end

  // ************************************************************
  // memory write back, skip request and result capture
  // ************************************************************
  always @* begin
    mem_wr_d = 1'b0;
    mem_data_d = mem_data_q;
    skip_d = 1'b0;
    result_d = result_q;
    skips_d = skips_q;
    if (op_go) begin
      case (i_op_code)
        `SBSZ_OP_SUB_TO_ACCUM: begin
          result_d = diff;
        end
        `SBSZ_OP_SUB_MEM: begin
          // accumulator left untouched, difference goes to memory
          mem_wr_d = 1'b1;
          mem_data_d = diff;
          result_d = diff;
        end
        `SBSZ_OP_DEC_SKIP: begin
          // write back only, flags untouched
          mem_wr_d = 1'b1;
          mem_data_d = dec_val;
          result_d = dec_val;
          skip_d = dec_zero;
          if (dec_zero) begin
            skips_d = skips_q + {{(DATA_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          mem_wr_d = 1'b0;
        end
      endcase
    end
    if (i_reg_wr && reg_hit(i_reg_addr, `SBSZ_REG_SKIPS)) begin
      skips_d = {DATA_W{1'b0}};
    end
  end

  // ************************************************************
  // skip sequencer: one dummy fetch cycle after a decrement to zero
  // ************************************************************
  always @* begin
    state_d = state_q;
    dummy_cnt_d = dummy_cnt_q;
    case (state_q)
      ST_RUN: begin
        if (op_go && (i_op_code == `SBSZ_OP_DEC_SKIP) && dec_zero) begin
          state_d = ST_DUMMY;
          dummy_cnt_d = `SBSZ_DUMMY_CYCLES;
        end
      end
      ST_DUMMY: begin
        dummy_cnt_d = dummy_cnt_q - 2'h1;
        if (dummy_cnt_q == 2'h1) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
        dummy_cnt_d = 2'h0;
      end
    endcase
  end

  // ************************************************************
  // register read port, data one cycle after the strobe
  // ************************************************************
  always @* begin
    rdata_d = {DATA_W{1'b0}};
    if (i_reg_rd) begin
      case (i_reg_addr)
        `SBSZ_REG_ACCUM: begin
          rdata_d = acc_q;
        end
        `SBSZ_REG_FLAGS: begin
          rdata_d = {{(DATA_W-4){1'b0}}, ov_q, z_q, ac_q, c_q};
        end
        `SBSZ_REG_RESULT: begin
          rdata_d = result_q;
        end
        `SBSZ_REG_SKIPS: begin
          rdata_d = skips_q;
        end
        `SBSZ_REG_STATE: begin
          rdata_d = {{(DATA_W-1){1'b0}}, state_q};
        end
        default: begin
          rdata_d = {DATA_W{1'b0}};
        end
      endcase
    end
  end

  // ************************************************************
  // flip-flops
  // ************************************************************
  always @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= ST_RUN;
      dummy_cnt_q <= 2'h0;
      acc_q <= `SBSZ_RST_ACCUM;
      c_q <= 1'b0;
      ac_q <= 1'b0;
      z_q <= 1'b0;
      ov_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_data_q <= `SBSZ_RST_BYTE;
      skip_q <= 1'b0;
      result_q <= `SBSZ_RST_BYTE;
      skips_q <= `SBSZ_RST_BYTE;
      rdata_q <= `SBSZ_RST_BYTE;
    end else begin
      state_q <= state_d;
      dummy_cnt_q <= dummy_cnt_d;
      acc_q <= acc_d;
      c_q <= c_d;
      ac_q <= ac_d;
      z_q <= z_d;
      ov_q <= ov_d;
      mem_wr_q <= mem_wr_d;
      mem_data_q <= mem_data_d;
      skip_q <= skip_d;
      result_q <= result_d;
      skips_q <= skips_d;
      rdata_q <= rdata_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign o_mem_wr_en = mem_wr_q;
  assign o_mem_wr_data = mem_data_q;
  assign o_skip_req = skip_q;
  assign o_dummy_cycle = (state_q == ST_DUMMY);
  assign o_accumulator = acc_q;
  assign o_carry_flag = c_q;
  assign o_aux_carry_flag = ac_q;
  assign o_zero_flag = z_q;
  assign o_overflow_flag = ov_q;
  assign o_reg_rdata = rdata_q;

endmodule

/* tb/sbsz_core_monitor.sv */
`timescale 1ns/100ps
module sbsz_mon (
  input wire i_clk,
  input wire i_srst,
  input wire i_op_valid,
  input wire [1:0] i_op_code,
  input wire [7:0] i_mem_data,
  input wire o_op_ready,
  input wire o_mem_wr_en,
  input wire [7:0] o_mem_wr_data,
  input wire o_skip_req,
  input wire o_dummy_cycle,
  input wire [7:0] o_accumulator,
  input wire o_carry_flag,
  input wire o_aux_carry_flag,
  input wire o_zero_flag,
  input wire o_overflow_flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire tk = i_op_valid & o_op_ready;
  wire sub = tk & (i_op_code == 2'h1 | i_op_code == 2'h2);
  wire [3:0] flg = {o_overflow_flag, o_zero_flag, o_aux_carry_flag, o_carry_flag};
  acc_sub_a:
    assert property (tk && i_op_code == 2'h1 |=> !o_mem_wr_en && o_accumulator ==
      8'($past(o_accumulator) - $past(i_mem_data) - {7'h0, !$past(o_carry_flag)}))
      else $error("accumulator difference wrong");
  mem_sub_a:
    assert property (tk && i_op_code == 2'h2 |=> o_mem_wr_en && $stable(o_accumulator) &&
      o_mem_wr_data == 8'($past(o_accumulator) - $past(i_mem_data) - !$past(o_carry_flag)))
      else $error("memory difference wrong");
  carry_sign_a:
    assert property (sub |=> o_carry_flag == ({1'b0, $past(o_accumulator)} >=
      {1'b0, $past(i_mem_data)} + {8'h00, !$past(o_carry_flag)}))
      else $error("carry flag wrong");
  zero_flag_a:
    assert property (sub |=> o_zero_flag ==
      ((o_mem_wr_en ? o_mem_wr_data : o_accumulator) == 8'h00))
      else $error("zero flag wrong");
  dec_write_a:
    assert property (tk && i_op_code == 2'h3 |=> o_mem_wr_en && $stable(flg) &&
      $stable(o_accumulator) && o_mem_wr_data == 8'($past(i_mem_data) - 8'h01))
      else $error("decrement write wrong");
  dec_skip_a:
    assert property (tk && i_op_code == 2'h3 |=> o_skip_req == ($past(i_mem_data) == 8'h01))
      else $error("skip decision wrong");
  skip_dummy_a:
    assert property (o_skip_req |-> o_dummy_cycle && !o_op_ready ##1 o_op_ready && !o_dummy_cycle)
      else $error("dummy cycle wrong");
  skip_cause_a:
    assert property ($rose(o_skip_req) |-> $past(tk && i_op_code == 2'h3))
      else $error("skip without decrement");
endmodule

/* tb/sbsz_fetch_model.sv */
`timescale 1ns/100ps
module sbsz_fetch_model (
  input wire i_clk,
  input wire i_ready,
  output logic o_valid,
  output logic [1:0] o_code,
  output logic [7:0] o_data
);
  initial begin
    o_valid = 1'b0;
    o_code = 2'h0;
    o_data = 8'h5a;
  end
  // called at a rising edge; hold keeps valid up for a back-to-back follower
  task automatic issue(input logic [1:0] code, input logic [7:0] data, input bit hold);
    logic r;
    o_valid <= 1'b1;
    o_code <= code;
    o_data <= data;
    do begin
      @(negedge i_clk) r = i_ready;
      @(posedge i_clk);
    end while (r !== 1'b1);
    if (!hold) begin
      o_valid <= 1'b0;
      o_code <= 2'h0;
      o_data <= ~data;
    end
  endtask
endmodule

/* tb/subtract_borrow_skip_zero_tb.sv */
`timescale 1ns/100ps
`include "sbsz_consts.vh"
module subtract_borrow_skip_zero_tb;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [2:0] i_reg_addr = 3'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  wire i_op_valid;
  wire [1:0] i_op_code;
  wire [7:0] i_mem_data, o_mem_wr_data, o_accumulator, o_reg_rdata;
  wire o_op_ready, o_mem_wr_en, o_skip_req, o_dummy_cycle;
  wire o_carry_flag, o_aux_carry_flag, o_zero_flag, o_overflow_flag;
  wire [22:0] got = {o_mem_wr_en, o_mem_wr_data, o_skip_req, o_dummy_cycle, o_accumulator,
    o_overflow_flag, o_zero_flag, o_aux_carry_flag, o_carry_flag};
  logic [7:0] acc_m, last_wr, nskip, res_m;
  logic [3:0] flg_m;
  logic [22:0] exp_q[$];
  logic [22:0] e;
  logic [31:0] v;
  logic pend = 1'b0;
  int n_mismatch = 0;
  int comparisons = 0;
  integer seed = 32'h4c67;
  always #5 i_clk = ~i_clk;
  sbsz_core dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_op_valid(i_op_valid),
    .i_op_code(i_op_code), .i_mem_data(i_mem_data), .o_op_ready(o_op_ready),
    .o_mem_wr_en(o_mem_wr_en), .o_mem_wr_data(o_mem_wr_data), .o_skip_req(o_skip_req),
    .o_dummy_cycle(o_dummy_cycle), .o_accumulator(o_accumulator),
    .o_carry_flag(o_carry_flag), .o_aux_carry_flag(o_aux_carry_flag),
    .o_zero_flag(o_zero_flag), .o_overflow_flag(o_overflow_flag),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
  sbsz_fetch_model mdl_u (.i_clk(i_clk), .i_ready(o_op_ready), .o_valid(i_op_valid),
    .o_code(i_op_code), .o_data(i_mem_data));
  // ****************************************
  // bus tasks and op prediction
  // ****************************************
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic reg_rd(input logic [2:0] a, input logic [7:0] x);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_clk);
    comparisons++;
    if (o_reg_rdata !== x) begin
      $display("Error rdata at %h expected %h seen %h", a, x, o_reg_rdata);
      n_mismatch++;
    end
    @(posedge i_clk);
  endtask
  task automatic set(input logic [7:0] a, input logic [3:0] f);
    reg_wr(`SBSZ_REG_ACCUM, a);
    reg_wr(`SBSZ_REG_FLAGS, {4'h0, f});
    acc_m = a;
    flg_m = f;
  endtask
  task automatic op(input logic [1:0] code, input logic [7:0] m, input bit hold);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] r;
    logic w;
    logic k;
    w = code[1];
    d = {1'b0, acc_m} - {1'b0, m} - {8'h00, ~flg_m[0]};
    h = {1'b0, acc_m[3:0]} - {1'b0, m[3:0]} - {4'h0, ~flg_m[0]};
    r = (code == `SBSZ_OP_DEC_SKIP) ? m - 8'h01 : d[7:0];
    k = (code == `SBSZ_OP_DEC_SKIP) && (r == 8'h00);
    nskip = nskip + {7'h0, k};
    if (code == `SBSZ_OP_SUB_TO_ACCUM || code == `SBSZ_OP_SUB_MEM)
      flg_m = {(acc_m[7] ^ m[7]) & (r[7] ^ acc_m[7]), r == 8'h00, ~h[4], ~d[8]};
    if (code == `SBSZ_OP_SUB_TO_ACCUM)
      acc_m = r;
    if (w)
      last_wr = r;
    if (code != `SBSZ_OP_NONE)
      res_m = r;
    exp_q.push_back({w, last_wr, k, k, acc_m, flg_m});
    mdl_u.issue(code, m, hold);
    if (!hold) @(posedge i_clk);
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge i_clk) begin
    if (pend) begin
      comparisons++;
      e = exp_q.pop_front();
      if (got !== e) begin
        $display("Error op result expected %h seen %h", e, got);
        n_mismatch++;
      end
    end
    pend <= i_op_valid & o_op_ready & ~i_srst;
  end
  initial begin
    #400000;
    n_mismatch++;
    $display("Error watchdog expected done seen hang");
    report_and_stop;
  end
  initial begin
    acc_m = 8'h00;
    flg_m = 4'h0;
    last_wr = 8'h00;
    nskip = 8'h00;
    res_m = 8'h00;
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    reg_rd(`SBSZ_REG_ACCUM, 8'h00);
    reg_rd(3'h7, 8'h00);
    set(8'h00, 4'h0);
    op(`SBSZ_OP_SUB_TO_ACCUM, 8'h00, 0);
    set(8'h80, 4'h1);
    op(`SBSZ_OP_SUB_MEM, 8'h01, 0);
    set(8'h35, 4'h1);
    op(`SBSZ_OP_SUB_TO_ACCUM, 8'h35, 1);
    op(`SBSZ_OP_SUB_MEM, 8'h01, 0);
    op(`SBSZ_OP_DEC_SKIP, 8'h01, 1);
    op(`SBSZ_OP_SUB_TO_ACCUM, 8'h22, 1);
    op(`SBSZ_OP_DEC_SKIP, 8'h00, 0);
    op(`SBSZ_OP_NONE, 8'h77, 0);
    repeat (40) begin
      v = $random(seed);
      set(v[7:0], v[11:8]);
      op(v[13:12] == 2'h0 ? 2'h2 : v[13:12], v[23:16], 1);
      op(2'h1 + {1'b0, v[14]}, v[31:24], 0);
    end
    reg_rd(`SBSZ_REG_ACCUM, acc_m);
    reg_rd(`SBSZ_REG_FLAGS, {4'h0, flg_m});
    reg_rd(`SBSZ_REG_SKIPS, nskip);
    reg_wr(`SBSZ_REG_RESULT, 8'hff);
    reg_rd(`SBSZ_REG_RESULT, res_m);
    reg_rd(`SBSZ_REG_STATE, 8'h00);
    reg_wr(`SBSZ_REG_SKIPS, 8'h5a);
    reg_rd(`SBSZ_REG_SKIPS, 8'h00);
    repeat (3) @(posedge i_clk);
    report_and_stop;
  end
endmodule
bind sbsz_core sbsz_mon mon_u (.i_clk(i_clk), .i_srst(i_srst), .i_op_valid(i_op_valid),
  .i_op_code(i_op_code), .i_mem_data(i_mem_data), .o_op_ready(o_op_ready),
  .o_mem_wr_en(o_mem_wr_en), .o_mem_wr_data(o_mem_wr_data), .o_skip_req(o_skip_req),
  .o_dummy_cycle(o_dummy_cycle), .o_accumulator(o_accumulator),
  .o_carry_flag(o_carry_flag), .o_aux_carry_flag(o_aux_carry_flag),
  .o_zero_flag(o_zero_flag), .o_overflow_flag(o_overflow_flag));
